//--- common/tpc_consts.svh
// offsets, field positions and reset values of the timer pulse unit block
`ifndef TPC_CONSTS_SVH
`define TPC_CONSTS_SVH

// ****************************************
// register bus shape
// ****************************************
`define TPC_ADDR_W 8
`define TPC_DATA_W 16

// ****************************************
// register byte offsets
// ****************************************
`define TPC_OFF_CTRL 8'h00
`define TPC_OFF_CNT 8'h02
`define TPC_OFF_GRA 8'h04
`define TPC_OFF_GRB 8'h06
`define TPC_OFF_BUFA 8'h08
`define TPC_OFF_STAT 8'h0a
`define TPC_OFF_IEN 8'h0c

// ****************************************
// control register fields
// ****************************************
`define TPC_CTRL_RUN 0
`define TPC_CTRL_EXT 1
`define TPC_CTRL_DOWN 2
`define TPC_CTRL_CLR_LO 3
`define TPC_CTRL_CLR_HI 4
`define TPC_CTRL_CAPA 5
`define TPC_CTRL_CAPB 6
`define TPC_CTRL_BUFA 7
`define TPC_CTRL_OEA 8
`define TPC_CTRL_OEB 9
`define TPC_CTRL_MASK 16'h03ff

// ****************************************
// status and enable register fields
// ****************************************
`define TPC_ST_GA 0
`define TPC_ST_GB 1
`define TPC_ST_OVF 4
`define TPC_ST_UDF 5
`define TPC_ST_MASK 16'h0033

// ****************************************
// reset values
// ****************************************
`define TPC_CTRL_RST 16'h0000
`define TPC_CNT_RST 16'h0000
`define TPC_GR_RST 16'hffff
`define TPC_STAT_RST 16'h0000

`endif

//--- common/tpc_pkg.sv
// types shared by the timer pulse unit block
package tpc_pkg;

  // phase of a cpu register access: the strobe cycle is the first state
  typedef enum logic [1:0] {
    PH_IDLE = 2'b00,
    PH_T2 = 2'b01
  } tpc_bus_phase_t;

  // counter clear source
  typedef enum logic [1:0] {
    CLR_NONE = 2'b00,
    CLR_GRA = 2'b01,
    CLR_GRB = 2'b11
  } tpc_clr_src_t;

endpackage

//--- tb/testbench.sv
// self-checking bench for the timer channel contention logic
`timescale 1ns/1ps
`include "tpc_consts.svh"
module testbench;
  import tpc_pkg::*;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic pin_a = 1'b0;
  logic ce = 1'b1, ext_a = 1'b0, pin_b = 1'b0;
  logic [7:0] addr;
  logic [15:0] wdata, rdata, v, k, w, d;
  logic wr, rd, irq, oa, oea, ob, oeb, o;
  tpc_bus_phase_t phase;
  int failures = 0;
  int checked = 0;
  int i, n, p;
  logic [31:0] seed = 32'd26;
  // free running clock
  initial forever #5 clock = ~clock;
  tpc_cpu_model cpu (.clock(clock), .bus_addr(addr), .bus_wdata(wdata), .bus_wr(wr), .bus_rd(rd),
    .bus_rdata(rdata));
  tpc_timer_unit dut (.clock(clock), .rst(rst), .ce(ce), .bus_addr(addr), .bus_wdata(wdata),
    .bus_wr(wr), .bus_rd(rd), .bus_rdata(rdata), .bus_phase(phase), .timer_irq(irq),
    .ext_clock_in_a(ext_a), .capture_compare_pin_a_in(pin_a), .capture_compare_pin_a_out(oa),
    .capture_compare_pin_a_oe(oea), .capture_compare_pin_b_in(pin_b), .capture_compare_pin_b_out(ob),
    .capture_compare_pin_b_oe(oeb));
  // xorshift stream
  function automatic logic [15:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[15:0];
  endfunction
  // clear on compare match counts the compare value plus one
  function automatic logic [15:0] clear_period(input logic [15:0] gr);
    return gr + 16'h0001;
  endfunction
  task automatic wrap_up;
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic rchk(input string nm, input logic [7:0] a, input logic [15:0] exp);
    logic [15:0] r;
    cpu.rd(a, r);
    chk(nm, r, exp);
  endtask
  task automatic ichk(input logic e);
    chk("irq", {15'h0000, irq}, {15'h0000, e});
  endtask
  // cycles from one toggle of pin a to the next, bounded
  task automatic toggle_gap(output int g);
    logic s;
    #1;
    for (int t = 0; t < 2; t++) begin
      s = oa;
      g = 0;
      while (oa === s && g < 200) begin
        @(posedge clock);
        #1;
        g++;
      end
      if (g >= 200) begin
        failures++;
        wrap_up();
      end
    end
  endtask
  // main sequence
  initial begin
    repeat (8) @(posedge clock);
    rst <= 1'b0;
    cpu.cyc(1);
    rchk("ctrl", `TPC_OFF_CTRL, `TPC_CTRL_RST);
    rchk("cnt", `TPC_OFF_CNT, `TPC_CNT_RST);
    rchk("gra", `TPC_OFF_GRA, `TPC_GR_RST);
    rchk("grb", `TPC_OFF_GRB, `TPC_GR_RST);
    rchk("bufa", `TPC_OFF_BUFA, `TPC_GR_RST);
    rchk("stat", `TPC_OFF_STAT, `TPC_STAT_RST);
    rchk("ien", `TPC_OFF_IEN, 16'h0000);
    cpu.wr(8'h0e, 16'hffff);
    cpu.cyc(1);
    rchk("unmapped", 8'h0e, 16'h0000);
    $display("test reset done");
    for (i = 0; i < 2; i++) begin
      v = rnd();
      n = (i == 0) ? 0 : 3 + v[3:0];
      cpu.wr(`TPC_OFF_CNT, 16'h0000);
      cpu.wr(`TPC_OFF_GRA, n[15:0]);
      cpu.wr(`TPC_OFF_CTRL, 16'h0109);
      cpu.cyc(1);
      toggle_gap(p);
      chk("period", p[15:0], clear_period(n[15:0]));
      chk("oe_a", {15'h0000, oea}, 16'h0001);
      if (i == 0) begin
        cpu.wr(`TPC_OFF_CNT, 16'h5a5a);
        rchk("wr_vs_clear", `TPC_OFF_CNT, 16'h0000);
      end
      cpu.stop();
    end
    $display("test period done");
    v = rnd();
    v = v & 16'h7fff;
    cpu.wr(`TPC_OFF_CTRL, 16'h0001);
    cpu.wr(`TPC_OFF_CNT, v);
    rchk("wr_vs_count", `TPC_OFF_CNT, v);
    cpu.stop();
    cpu.clr_stat();
    cpu.wr(`TPC_OFF_CNT, 16'hffff);
    cpu.wr(`TPC_OFF_CTRL, 16'h0001);
    cpu.wr(`TPC_OFF_CNT, 16'h1234);
    cpu.cyc(2);
    cpu.stop();
    cpu.rd(`TPC_OFF_STAT, d);
    chk("ovf_vs_write", d & 16'h0030, 16'h0000);
    cpu.wr(`TPC_OFF_GRA, 16'hffff);
    cpu.wr(`TPC_OFF_CNT, 16'hfff0);
    cpu.wr(`TPC_OFF_CTRL, 16'h0009);
    cpu.cyc(1);
    cpu.clr_stat();
    cpu.cyc(30);
    cpu.stop();
    cpu.wr(`TPC_OFF_STAT, 16'h0000);
    cpu.rd(`TPC_OFF_STAT, d);
    chk("ovf_vs_clear", d & 16'h0031, 16'h0001);
    chk("zero_unread", d & 16'h0001, 16'h0001);
    $display("test counter done");
    ichk(1'b0);
    cpu.wr(`TPC_OFF_IEN, 16'h0001);
    cpu.cyc(2);
    ichk(1'b1);
    cpu.wr(`TPC_OFF_IEN, 16'h0030);
    cpu.cyc(2);
    ichk(1'b0);
    cpu.wr(`TPC_OFF_IEN, 16'h0001);
    cpu.wr(`TPC_OFF_STAT, 16'hffff);
    cpu.cyc(2);
    ichk(1'b1);
    cpu.clr_stat();
    ichk(1'b0);
    $display("test irq done");
    v = rnd();
    k = v & 16'h7fff;
    w = k | 16'h8000;
    cpu.wr(`TPC_OFF_CNT, k);
    cpu.wr(`TPC_OFF_GRA, k);
    cpu.cyc(2);
    o = oa;
    cpu.wr(`TPC_OFF_CTRL, 16'h0001);
    cpu.wr(`TPC_OFF_GRA, k);
    cpu.cyc(8);
    cpu.stop();
    cpu.rd(`TPC_OFF_STAT, d);
    chk("match_vs_write", d & 16'h0001, 16'h0000);
    chk("out_held", {15'h0000, oa}, {15'h0000, o});
    cpu.wr(`TPC_OFF_CNT, k);
    cpu.wr(`TPC_OFF_GRA, k);
    cpu.wr(`TPC_OFF_CTRL, 16'h0281);
    cpu.wr(`TPC_OFF_BUFA, w);
    cpu.cyc(4);
    chk("oe_b", {15'h0000, oeb}, 16'h0001);
    cpu.stop();
    rchk("buf_xfer", `TPC_OFF_GRA, w);
    cpu.wr(`TPC_OFF_CNT, k);
    cpu.wr(`TPC_OFF_CTRL, 16'h0020);
    cpu.cyc(2);
    // pin edge timed so the capture lands in the read strobe cycle
    @(posedge clock);
    pin_a <= 1'b1;
    cpu.cyc(1);
    rchk("capture", `TPC_OFF_GRA, k);
    cpu.stop();
    // captures timed into the second state of a buffer and a register write
    @(posedge clock);
    pin_a <= 1'b0;
    cpu.wr(`TPC_OFF_CNT, w);
    cpu.wr(`TPC_OFF_CTRL, 16'h00e0);
    cpu.cyc(4);
    @(posedge clock);
    pin_a <= 1'b1;
    cpu.wr(`TPC_OFF_BUFA, ~k);
    pin_b <= 1'b1;
    cpu.wr(`TPC_OFF_GRB, ~k);
    cpu.cyc(2);
    rchk("cap_vs_wr", `TPC_OFF_GRB, w);
    rchk("cap_vs_buf", `TPC_OFF_BUFA, k);
    rchk("cap_buf_gr", `TPC_OFF_GRA, w);
    cpu.stop();
    $display("test compare capture done");
    // external clock: n live pulses, then one pulse lost while ce is low
    v = rnd();
    n = 1 + v[2:0];
    cpu.wr(`TPC_OFF_CNT, 16'h0000);
    cpu.wr(`TPC_OFF_GRA, n[15:0]);
    cpu.wr(`TPC_OFF_GRB, n[15:0] - 16'h0001);
    cpu.wr(`TPC_OFF_CTRL, 16'h0003);
    cpu.clr_stat();
    o = ob;
    for (i = 0; i <= n; i++) begin
      @(posedge clock);
      ce <= (i < n);
      ext_a <= 1'b1;
      repeat (2) @(posedge clock);
      ext_a <= 1'b0;
      repeat (2) @(posedge clock);
    end
    ce <= 1'b1;
    cpu.cyc(1);
    rchk("ext_count", `TPC_OFF_CNT, n[15:0]);
    cpu.rd(`TPC_OFF_STAT, d);
    chk("match_once", d & 16'h0003, 16'h0002);
    chk("out_b", {15'h0000, ob}, {15'h0000, ~o});
    cpu.stop();
    $display("test ext clock done");
    wrap_up();
  end
endmodule

//--- tb/tpc_cpu_model.sv
// register bus master standing in for the cpu
`timescale 1ns/1ps
`include "tpc_consts.svh"
module tpc_cpu_model (
  input wire logic clock,
  output logic [`TPC_ADDR_W-1:0] bus_addr,
  output logic [15:0] bus_wdata,
  output logic bus_wr,
  output logic bus_rd,
  input wire logic [15:0] bus_rdata
);
  // bus idle at time zero
  initial begin
    bus_addr = 8'h00;
    bus_wdata = 16'h0000;
    bus_wr = 1'b0;
    bus_rd = 1'b0;
  end
  // idle cycles: address and data wander so stale values are never trusted
  task automatic cyc(input int n);
    repeat (n) begin
      @(posedge clock);
      bus_wr <= 1'b0;
      bus_rd <= 1'b0;
      bus_addr <= ~bus_addr;
      bus_wdata <= ~bus_wdata;
    end
    #1;
  endtask
  // one strobe cycle; the caller ends it with another access or cyc
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clock);
    bus_addr <= a;
    bus_wdata <= d;
    bus_rd <= 1'b0;
    bus_wr <= 1'b1;
  endtask
  // read data taken in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge clock);
    bus_addr <= a;
    bus_wdata <= ~bus_wdata;
    bus_wr <= 1'b0;
    bus_rd <= 1'b1;
    @(posedge clock);
    bus_rd <= 1'b0;
    #1;
    d = bus_rdata;
  endtask
  // flags clear only by a zero written after reading them as one
  task automatic clr_stat;
    logic [15:0] d;
    rd(`TPC_OFF_STAT, d);
    wr(`TPC_OFF_STAT, ~d);
    cyc(2);
  endtask
  // interrupts are masked before the timer is stopped
  task automatic stop;
    wr(`TPC_OFF_IEN, 16'h0000);
    wr(`TPC_OFF_CTRL, 16'h0000);
    cyc(2);
  endtask
endmodule

//--- tb/tpc_timer_assertions.sv
// port-level checks of the timer channel bus and interrupt behaviour
`timescale 1ns/1ps
`include "tpc_consts.svh"
module tpc_timer_assertions #(
  parameter int DW = `TPC_DATA_W
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic ce,
  input wire logic [`TPC_ADDR_W-1:0] bus_addr,
  input wire logic [DW-1:0] bus_wdata,
  input wire logic bus_wr,
  input wire logic bus_rd,
  input wire logic [DW-1:0] bus_rdata,
  input wire tpc_pkg::tpc_bus_phase_t bus_phase,
  input wire logic timer_irq,
  input wire logic ext_clock_in_a,
  input wire logic capture_compare_pin_a_in,
  input wire logic capture_compare_pin_a_out,
  input wire logic capture_compare_pin_a_oe,
  input wire logic capture_compare_pin_b_in,
  input wire logic capture_compare_pin_b_out,
  input wire logic capture_compare_pin_b_oe
);
  import tpc_pkg::*;
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  // steps of a register access
  sequence s_wr;
    ce && bus_wr;
  endsequence
  sequence s_quiet;
    ce && !bus_wr;
  endsequence
  // the cycle after a write strobe is its second state
  a_wr_second_state: assert property (s_wr |=> bus_phase == PH_T2)
    else $error("phase not second state after write");
  a_write_walk: assert property (s_wr ##1 s_quiet |=> bus_phase == PH_IDLE)
    else $error("phase not idle after write");
  a_burst_second: assert property (s_wr ##1 s_wr |=> bus_phase == PH_T2)
    else $error("phase lost in write burst");
  // read data stand only in the cycle after the read strobe
  a_rdata_idle: assert property ((ce && !bus_rd) |=> bus_rdata == '0)
    else $error("read data outside read answer");
  // the request drops only through a register write
  a_irq_fall_cause: assert property ($fell(timer_irq) |-> $past(bus_phase) == PH_T2)
    else $error("interrupt dropped without write");
  a_oe_a_cause: assert property ($changed(capture_compare_pin_a_oe) |->
    ($past(bus_phase) == PH_T2 || $past(bus_phase, 2) == PH_T2))
    else $error("pin a enable changed without write");
  a_oe_b_cause: assert property ($changed(capture_compare_pin_b_oe) |->
    ($past(bus_phase) == PH_T2 || $past(bus_phase, 2) == PH_T2))
    else $error("pin b enable changed without write");
  a_reset_quiet: assert property ($fell(rst) |-> !timer_irq && bus_rdata == '0 && bus_phase == PH_IDLE
    && !capture_compare_pin_a_oe && !capture_compare_pin_b_oe)
    else $error("outputs not quiet after reset");
endmodule

bind tpc_timer_unit tpc_timer_assertions #(.DW(DW)) u_chk (.clock(clock), .rst(rst), .ce(ce),
  .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
  .bus_phase(bus_phase), .timer_irq(timer_irq), .ext_clock_in_a(ext_clock_in_a),
  .capture_compare_pin_a_in(capture_compare_pin_a_in), .capture_compare_pin_a_out(capture_compare_pin_a_out),
  .capture_compare_pin_a_oe(capture_compare_pin_a_oe), .capture_compare_pin_b_in(capture_compare_pin_b_in),
  .capture_compare_pin_b_out(capture_compare_pin_b_out), .capture_compare_pin_b_oe(capture_compare_pin_b_oe));

//--- verilog/tpc_sync_edge.sv
// two flip-flop synchroniser with edge detection for one pin
`timescale 1ns/1ps
module tpc_sync_edge (
  input wire logic clock,
  input wire logic rst,
  input wire logic ce,
  input wire logic din,
  output logic rise,
  output logic fall
);

  logic meta_reg;
  logic sync_reg;
  logic last_reg;

  // ****************************************
  // synchroniser and history
  // ****************************************
  // first stage feeds only the second stage
  always_ff @(posedge clock) begin
    if (rst) begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
      last_reg <= 1'b0;
    end else if (ce) begin
      meta_reg <= din;
      sync_reg <= meta_reg;
      last_reg <= sync_reg;
    end
  end

  // edges seen on the synchronised level
  assign rise = sync_reg & ~last_reg;
  assign fall = ~sync_reg & last_reg;

endmodule

//--- verilog/tpc_timer_unit.sv
// one channel of a 16-bit timer pulse unit with its bus contention logic
`timescale 1ns/1ps
`include "tpc_consts.svh"
module tpc_timer_unit #(
  parameter int DW = `TPC_DATA_W
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic ce,
  input wire logic [`TPC_ADDR_W-1:0] bus_addr,
  input wire logic [DW-1:0] bus_wdata,
  input wire logic bus_wr,
  input wire logic bus_rd,
  output logic [DW-1:0] bus_rdata,
  output tpc_pkg::tpc_bus_phase_t bus_phase,
  output logic timer_irq,
  input wire logic ext_clock_in_a,
  input wire logic capture_compare_pin_a_in,
  output logic capture_compare_pin_a_out,
  output logic capture_compare_pin_a_oe,
  input wire logic capture_compare_pin_b_in,
  output logic capture_compare_pin_b_out,
  output logic capture_compare_pin_b_oe
);
  import tpc_pkg::*;

  localparam logic [DW-1:0] ONE = {{(DW-1){1'b0}}, 1'b1};
  localparam logic [DW-1:0] ZERO = '0;
  localparam logic [DW-1:0] MAXV = '1;

  // ****************************************
  // address decode
  // ****************************************
  function automatic logic hit(input logic [`TPC_ADDR_W-1:0] a, input logic [`TPC_ADDR_W-1:0] off);
    hit = (a == off);
  endfunction

  // ****************************************
  // state
  // ****************************************
  tpc_bus_phase_t phase_reg;
  logic [`TPC_ADDR_W-1:0] pend_addr_reg;
  logic [DW-1:0] pend_data_reg;
  logic [DW-1:0] ctrl_reg;
  logic [DW-1:0] up_down_counter_reg;
  logic [DW-1:0] gra_reg;
  logic [DW-1:0] grb_reg;
  logic [DW-1:0] bufa_reg;
  logic [DW-1:0] timer_status_reg;
  logic [DW-1:0] timer_irq_enable_reg;
  logic [DW-1:0] armed_reg;
  logic [DW-1:0] rdata_reg;
  logic irq_reg;
  logic pin_a_out_reg;
  logic pin_b_out_reg;
  logic pin_a_oe_reg;
  logic pin_b_oe_reg;

  logic [DW-1:0] cnt_next;
  logic [DW-1:0] gra_next;
  logic [DW-1:0] grb_next;
  logic [DW-1:0] bufa_next;
  logic [DW-1:0] ctrl_next;
  logic [DW-1:0] ien_next;
  logic [DW-1:0] stat_next;
  logic [DW-1:0] stat_set;
  logic [DW-1:0] stat_clr;
  logic [DW-1:0] read_value;

  // ****************************************
  // pin synchronisers
  // ****************************************
  logic [2:0] pin_raw;
  logic [2:0] pin_rise;
  assign pin_raw = {capture_compare_pin_b_in, capture_compare_pin_a_in, ext_clock_in_a};

  // one synchroniser per pin
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi = gi + 1) begin : g_sync
      tpc_sync_edge u_sync (
        .clock(clock),
        .rst(rst),
        .ce(ce),
        .din(pin_raw[gi]),
        .rise(pin_rise[gi]),
        .fall()
      );
    end
  endgenerate

  // ****************************************
  // control fields
  // ****************************************
  logic run;
  logic ext_sel;
  logic down;
  logic cap_mode_a;
  logic cap_mode_b;
  logic buf_mode_a;
  tpc_clr_src_t clr_src;
  assign run = ctrl_reg[`TPC_CTRL_RUN];
  assign ext_sel = ctrl_reg[`TPC_CTRL_EXT];
  assign down = ctrl_reg[`TPC_CTRL_DOWN];
  assign cap_mode_a = ctrl_reg[`TPC_CTRL_CAPA];
  assign cap_mode_b = ctrl_reg[`TPC_CTRL_CAPB];
  assign buf_mode_a = ctrl_reg[`TPC_CTRL_BUFA];
  assign clr_src = tpc_clr_src_t'(ctrl_reg[`TPC_CTRL_CLR_HI:`TPC_CTRL_CLR_LO]);

  // ****************************************
  // second state of a write cycle
  // ****************************************
  logic t2_wr;
  logic wr_ctrl;
  logic wr_cnt;
  logic wr_gra;
  logic wr_grb;
  logic wr_bufa;
  logic wr_stat;
  logic wr_ien;
  assign t2_wr = (phase_reg == PH_T2);
  assign wr_ctrl = t2_wr && hit(pend_addr_reg, `TPC_OFF_CTRL);
  assign wr_cnt = t2_wr && hit(pend_addr_reg, `TPC_OFF_CNT);
  assign wr_gra = t2_wr && hit(pend_addr_reg, `TPC_OFF_GRA);
  assign wr_grb = t2_wr && hit(pend_addr_reg, `TPC_OFF_GRB);
  assign wr_bufa = t2_wr && hit(pend_addr_reg, `TPC_OFF_BUFA);
  assign wr_stat = t2_wr && hit(pend_addr_reg, `TPC_OFF_STAT);
  assign wr_ien = t2_wr && hit(pend_addr_reg, `TPC_OFF_IEN);

  // ****************************************
  // timer events
  // ****************************************
  logic tick;
  logic match_a;
  logic match_b;
  logic cap_a;
  logic cap_b;
  logic ovf;
  logic udf;
  logic clr_evt;

  // counter input clock: every cycle or a rising edge on the external pin
  assign tick = run && (ext_sel ? pin_rise[0] : 1'b1);
  // match only on a counter input clock, so equality alone repeats nothing
  assign match_a = tick && !cap_mode_a && (up_down_counter_reg == gra_reg) && !wr_gra;
  assign match_b = tick && !cap_mode_b && (up_down_counter_reg == grb_reg) && !wr_grb;
  assign cap_a = cap_mode_a && pin_rise[1];
  assign cap_b = cap_mode_b && pin_rise[2];
  assign ovf = tick && !down && (up_down_counter_reg == MAXV);
  assign udf = tick && down && (up_down_counter_reg == ZERO);

  // clear source selects the event of one register
  always_comb begin
    case (clr_src)
      CLR_GRA: clr_evt = match_a || cap_a;
      CLR_GRB: clr_evt = match_b || cap_b;
      default: clr_evt = 1'b0;
    endcase
  end

  // ****************************************
  // next values of the data registers
  // ****************************************
  // counter: clear, then cpu write, then count
  always_comb begin
    if (clr_evt) begin
      cnt_next = ZERO;
    end else if (wr_cnt) begin
      cnt_next = pend_data_reg;
    end else if (tick && down) begin
      cnt_next = up_down_counter_reg - ONE;
    end else if (tick) begin
      cnt_next = up_down_counter_reg + ONE;
    end else begin
      cnt_next = up_down_counter_reg;
    end
  end

  // register a: capture, then cpu write, then buffer transfer on match
  always_comb begin
    if (cap_a) begin
      gra_next = up_down_counter_reg;
    end else if (wr_gra) begin
      gra_next = pend_data_reg;
    end else if (buf_mode_a && match_a) begin
      gra_next = wr_bufa ? pend_data_reg : bufa_reg;
    end else begin
      gra_next = gra_reg;
    end
  end

  // register b: capture beats the cpu write
  always_comb begin
    if (cap_b) begin
      grb_next = up_down_counter_reg;
    end else if (wr_grb) begin
      grb_next = pend_data_reg;
    end else begin
      grb_next = grb_reg;
    end
  end

  // buffer: capture transfer beats the cpu write
  always_comb begin
    if (buf_mode_a && cap_a) begin
      bufa_next = gra_reg;
    end else if (wr_bufa) begin
      bufa_next = pend_data_reg;
    end else begin
      bufa_next = bufa_reg;
    end
  end

  // control and enable registers
  assign ctrl_next = wr_ctrl ? (pend_data_reg & `TPC_CTRL_MASK) : ctrl_reg;
  assign ien_next = wr_ien ? (pend_data_reg & `TPC_ST_MASK) : timer_irq_enable_reg;

  // ****************************************
  // status flags
  // ****************************************
  // overflow and underflow flags stay put under a clear or a counter write
  always_comb begin
    stat_set = ZERO;
    stat_set[`TPC_ST_GA] = match_a || cap_a;
    stat_set[`TPC_ST_GB] = match_b || cap_b;
    stat_set[`TPC_ST_OVF] = ovf && !clr_evt && !wr_cnt;
    stat_set[`TPC_ST_UDF] = udf && !clr_evt && !wr_cnt;
  end

  // a zero clears only a flag already read as one; a new event wins
  assign stat_clr = wr_stat ? (armed_reg & ~pend_data_reg) : ZERO;
  assign stat_next = ((timer_status_reg & ~stat_clr) | stat_set) & `TPC_ST_MASK;

  // ****************************************
  // read mux
  // ****************************************
  // reads see this cycle's updates, so a capture in the first state is returned
  always_comb begin
    if (hit(bus_addr, `TPC_OFF_CTRL)) begin
      read_value = ctrl_next;
    end else if (hit(bus_addr, `TPC_OFF_CNT)) begin
      read_value = cnt_next;
    end else if (hit(bus_addr, `TPC_OFF_GRA)) begin
      read_value = gra_next;
    end else if (hit(bus_addr, `TPC_OFF_GRB)) begin
      read_value = grb_next;
    end else if (hit(bus_addr, `TPC_OFF_BUFA)) begin
      read_value = bufa_next;
    end else if (hit(bus_addr, `TPC_OFF_STAT)) begin
      read_value = stat_next;
    end else if (hit(bus_addr, `TPC_OFF_IEN)) begin
      read_value = ien_next;
    end else begin
      read_value = ZERO; // unmapped
    end
  end

  // ****************************************
  // bus cycle sequencer
  // ****************************************
  // a write strobe is the first state; the commit happens in the next cycle
  always_ff @(posedge clock) begin
    if (rst) begin
      phase_reg <= PH_IDLE;
      pend_addr_reg <= '0;
      pend_data_reg <= ZERO;
    end else if (ce) begin
      if (bus_wr) begin
        phase_reg <= PH_T2;
        pend_addr_reg <= bus_addr;
        pend_data_reg <= bus_wdata;
      end else begin
        phase_reg <= PH_IDLE;
      end
    end
  end

  // read data stand only in the cycle after the strobe
  always_ff @(posedge clock) begin
    if (rst) begin
      rdata_reg <= ZERO;
    end else if (ce) begin
      rdata_reg <= bus_rd ? read_value : ZERO;
    end
  end

  // ****************************************
  // timer registers
  // ****************************************
  // counter and control
  always_ff @(posedge clock) begin
    if (rst) begin
      ctrl_reg <= `TPC_CTRL_RST;
      up_down_counter_reg <= `TPC_CNT_RST;
    end else if (ce) begin
      ctrl_reg <= ctrl_next;
      up_down_counter_reg <= cnt_next;
    end
  end

  // compare/capture and buffer registers
  always_ff @(posedge clock) begin
    if (rst) begin
      gra_reg <= `TPC_GR_RST;
      grb_reg <= `TPC_GR_RST;
      bufa_reg <= `TPC_GR_RST;
    end else if (ce) begin
      gra_reg <= gra_next;
      grb_reg <= grb_next;
      bufa_reg <= bufa_next;
    end
  end

  // ****************************************
  // status, enable and interrupt
  // ****************************************
  // status flags and their read-as-one marks
  always_ff @(posedge clock) begin
    if (rst) begin
      timer_status_reg <= `TPC_STAT_RST;
      armed_reg <= ZERO;
    end else if (ce) begin
      timer_status_reg <= stat_next;
      if (bus_rd && hit(bus_addr, `TPC_OFF_STAT)) begin
        armed_reg <= stat_next;
      end else begin
        armed_reg <= armed_reg & stat_next;
      end
    end
  end

  // interrupt request follows flags and enables with no extra lag
  always_ff @(posedge clock) begin
    if (rst) begin
      timer_irq_enable_reg <= ZERO;
      irq_reg <= 1'b0;
    end else if (ce) begin
      timer_irq_enable_reg <= ien_next;
      irq_reg <= |(stat_next & ien_next);
    end
  end

  // ****************************************
  // compare output pins
  // ****************************************
  // toggle on match; driven only when enabled in compare mode
  always_ff @(posedge clock) begin
    if (rst) begin
      pin_a_out_reg <= 1'b0;
      pin_b_out_reg <= 1'b0;
      pin_a_oe_reg <= 1'b0;
      pin_b_oe_reg <= 1'b0;
    end else if (ce) begin
      pin_a_oe_reg <= ctrl_next[`TPC_CTRL_OEA] && !ctrl_next[`TPC_CTRL_CAPA];
      pin_b_oe_reg <= ctrl_next[`TPC_CTRL_OEB] && !ctrl_next[`TPC_CTRL_CAPB];
      if (match_a) begin
        pin_a_out_reg <= !pin_a_out_reg;
      end
      if (match_b) begin
        pin_b_out_reg <= !pin_b_out_reg;
      end
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign bus_rdata = rdata_reg;
  assign bus_phase = phase_reg;
  assign timer_irq = irq_reg;
  assign capture_compare_pin_a_out = pin_a_out_reg;
  assign capture_compare_pin_a_oe = pin_a_oe_reg;
  assign capture_compare_pin_b_out = pin_b_out_reg;
  assign capture_compare_pin_b_oe = pin_b_oe_reg;

endmodule
